// ==== hw/vih_top.v ====
// Vectored interrupt handler: pending flags, masking, priority and vectoring.
`timescale 1ns/100ps
`default_nettype none
`include "vih_defines.vh"
module vih_top (
    input wire clk_in,
    input wire rstn_in,
    input wire ext_irq0_n_in,
    input wire ext_irq1_n_in,
    input wire ext0_edge_select_in,
    input wire ext1_edge_select_in,
    input wire [3:0] tcr_set_in,
    input wire [3:0] tcr_clr_in,
    input wire timer0_overflow_in,
    input wire timer1_overflow_in,
    input wire serial0_rx_flag_in,
    input wire serial0_tx_flag_in,
    input wire serial1_rx_flag_in,
    input wire serial1_tx_flag_in,
    input wire [20:0] periph_pending_in,
    input wire [20:0] source_enable_in,
    input wire [20:0] source_priority_in,
    input wire global_irq_enable_in,
    input wire global_clear_in,
    input wire auto_page_switch_enable_in,
    input wire instr_done_in,
    input wire next_multi_cycle_in,
    input wire return_from_irq_in,
    input wire [15:0] next_pc_in,
    output wire irq_request_out,
    output reg long_call_out,
    output reg [15:0] vector_addr_out,
    output reg [15:0] return_addr_out,
    output reg return_valid_out,
    output reg [7:0] page_select_out,
    output reg page_switch_out,
    output wire [3:0] timer_control_reg_out,
    output reg [1:0] active_level_out
);
    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    // Vector of an order slot.
    function [15:0] slot_vector;
        input [4:0] slot;
        begin
            slot_vector = `VIH_VEC_BASE + {8'h00, slot, 3'h0};
        end
    endfunction
    // Page associated with each slot.
    function [7:0] slot_page;
        input [4:0] slot;
        begin
            if (slot == 5'h0A || slot == 5'h0B || slot == 5'h0E || slot == `VIH_SLOT_SER1) begin
                slot_page = 8'h01;
            end else if (slot == 5'h0C || slot == 5'h0D || (slot >= 5'h10 && slot <= 5'h12)) begin
                slot_page = 8'h02;
            end else begin
                slot_page = `VIH_PAGE_RESET;
            end
        end
    endfunction
    // Lowest set bit index of a mask.
    function [4:0] first_set;
        input [20:0] mask;
        integer i;
        begin
            first_set = 5'h00;
            for (i = 20; i >= 0; i = i - 1) begin
                if (mask[i]) begin
                    first_set = i[4:0];
                end
            end
        end
    endfunction

    localparam ST_RUN = 2'h0;
    localparam ST_CALL = 2'h1;
    localparam ST_HOLD = 2'h2;

    reg [1:0] state_reg;
    reg [2:0] call_cnt_reg;
    reg [4:0] slot_reg;
    reg tf0_reg;
    reg tf1_reg;
    reg ea_eff_reg;
    reg hold_off_reg;
    reg [4:0] stack_slot_reg [0:1];
    wire ext0_pend;
    wire ext1_pend;
    wire ack_ext0;
    wire ack_ext1;
    wire [20:0] pending;
    wire [20:0] eligible;
    wire [20:0] hi_mask;
    wire any_hi;
    wire [4:0] win_slot;
    wire win_hi;
    wire allowed;
    wire take;

    // ---------------------------------------------------------------
    // External pins
    // ---------------------------------------------------------------
    assign ack_ext0 = long_call_out & (slot_reg == `VIH_SLOT_EXT0);
    assign ack_ext1 = long_call_out & (slot_reg == `VIH_SLOT_EXT1);
    vih_ext_pin u_ext0 (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .pin_n_in(ext_irq0_n_in),
        .edge_select_in(ext0_edge_select_in),
        .sw_set_in(tcr_set_in[`VIH_TCR_EXT0_PEND]),
        .sw_clr_in(tcr_clr_in[`VIH_TCR_EXT0_PEND]),
        .vector_ack_in(ack_ext0),
        .pending_out(ext0_pend)
    );
    vih_ext_pin u_ext1 (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .pin_n_in(ext_irq1_n_in),
        .edge_select_in(ext1_edge_select_in),
        .sw_set_in(tcr_set_in[`VIH_TCR_EXT1_PEND]),
        .sw_clr_in(tcr_clr_in[`VIH_TCR_EXT1_PEND]),
        .vector_ack_in(ack_ext1),
        .pending_out(ext1_pend)
    );
    // Pending flags and edge selects as seen in the timer control register.
    assign timer_control_reg_out = {ext1_pend, ext1_edge_select_in, ext0_pend,
                                    ext0_edge_select_in};

    // ---------------------------------------------------------------
    // Timer overflow flags
    // ---------------------------------------------------------------
    // Overflow sets, vectoring clears; set wins over clear.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tf0_reg <= 1'b0;
            tf1_reg <= 1'b0;
        end else begin
            if (timer0_overflow_in) begin
                tf0_reg <= 1'b1;
            end else if (long_call_out && slot_reg == `VIH_SLOT_TMR0) begin
                tf0_reg <= 1'b0;
            end
            if (timer1_overflow_in) begin
                tf1_reg <= 1'b1;
            end else if (long_call_out && slot_reg == `VIH_SLOT_TMR1) begin
                tf1_reg <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Pending vector
    // ---------------------------------------------------------------
    // Serial sources OR their flags; the reserved slot is tied off.
    genvar g;
    generate
        for (g = 0; g < `VIH_NSLOT; g = g + 1) begin : g_pend
            if (g == 0) begin : g_e0
                assign pending[g] = ext0_pend;
            end else if (g == 1) begin : g_t0
                assign pending[g] = tf0_reg;
            end else if (g == 2) begin : g_e1
                assign pending[g] = ext1_pend;
            end else if (g == 3) begin : g_t1
                assign pending[g] = tf1_reg;
            end else if (g == 4) begin : g_s0
                assign pending[g] = serial0_rx_flag_in | serial0_tx_flag_in;
            end else if (g == 19) begin : g_rs
                assign pending[g] = 1'b0;
            end else if (g == 20) begin : g_s1
                assign pending[g] = serial1_rx_flag_in | serial1_tx_flag_in;
            end else begin : g_pp
                assign pending[g] = periph_pending_in[g];
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Masking and priority decode
    // ---------------------------------------------------------------
    // Decoded every clock; high level first, then lowest order.
    assign eligible = pending & source_enable_in & {21{ea_eff_reg}};
    assign hi_mask = eligible & source_priority_in;
    assign any_hi = |hi_mask;
    assign win_slot = any_hi ? first_set(hi_mask) : first_set(eligible);
    assign win_hi = any_hi;
    // High preempts low; nothing preempts high; equal level waits.
    assign allowed = (active_level_out == 2'h0) ||
                     (win_hi && !active_level_out[1]);
    assign irq_request_out = (|eligible) & allowed & (state_reg == ST_RUN);
    assign take = irq_request_out & instr_done_in & ~hold_off_reg;

    // ---------------------------------------------------------------
    // Global enable pipeline
    // ---------------------------------------------------------------
    // A clear still lets one single-cycle follower be interrupted.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ea_eff_reg <= 1'b0;
        end else if (global_clear_in) begin
            ea_eff_reg <= ~next_multi_cycle_in & ea_eff_reg;
        end else begin
            ea_eff_reg <= global_irq_enable_in;
        end
    end

    // ---------------------------------------------------------------
    // Vectoring sequencer
    // ---------------------------------------------------------------
    // Four cycles of call; after return one instruction runs first.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ST_RUN;
            call_cnt_reg <= 3'h0;
            slot_reg <= 5'h00;
            long_call_out <= 1'b0;
            vector_addr_out <= `VIH_VEC_RESET;
            return_addr_out <= 16'h0000;
            return_valid_out <= 1'b0;
            page_select_out <= `VIH_PAGE_RESET;
            page_switch_out <= 1'b0;
            active_level_out <= 2'h0;
            hold_off_reg <= 1'b0;
            stack_slot_reg[0] <= 5'h00;
            stack_slot_reg[1] <= 5'h00;
        end else begin
            long_call_out <= 1'b0;
            page_switch_out <= 1'b0;
            return_valid_out <= 1'b0;
            case (state_reg)
                ST_RUN: begin
                    if (return_from_irq_in) begin
                        return_valid_out <= 1'b1;
                        hold_off_reg <= 1'b1;
                        if (active_level_out[1]) begin
                            active_level_out[1] <= 1'b0;
                        end else begin
                            active_level_out[0] <= 1'b0;
                        end
                    end else if (take) begin
                        slot_reg <= win_slot;
                        vector_addr_out <= slot_vector(win_slot);
                        return_addr_out <= next_pc_in;
                        call_cnt_reg <= `VIH_CALL_CYCLES - 3'h1;
                        state_reg <= ST_CALL;
                        if (win_hi) begin
                            active_level_out[1] <= 1'b1;
                            stack_slot_reg[1] <= win_slot;
                        end else begin
                            active_level_out[0] <= 1'b1;
                            stack_slot_reg[0] <= win_slot;
                        end
                    end else if (instr_done_in) begin
                        hold_off_reg <= 1'b0;
                    end
                end
                ST_CALL: begin
                    if (call_cnt_reg == 3'h1) begin
                        long_call_out <= 1'b1;
                        state_reg <= ST_HOLD;
                        if (auto_page_switch_enable_in) begin
                            page_select_out <= slot_page(slot_reg);
                            page_switch_out <= 1'b1;
                        end
                    end
                    call_cnt_reg <= call_cnt_reg - 3'h1;
                end
                ST_HOLD: begin
                    state_reg <= ST_RUN;
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== hw/vih_defines.vh ====
// Constants shared by the vectored interrupt handler files.
`ifndef VIH_DEFINES_VH
`define VIH_DEFINES_VH
// ---------------------------------------------------------------
// Source slots and vectors
// ---------------------------------------------------------------
`define VIH_NSLOT 21
`define VIH_SLOT_W 5
`define VIH_VEC_BASE 16'h0003
`define VIH_VEC_STEP 16'h0008
`define VIH_VEC_RESET 16'h0000
`define VIH_SLOT_EXT0 5'h00
`define VIH_SLOT_TMR0 5'h01
`define VIH_SLOT_EXT1 5'h02
`define VIH_SLOT_TMR1 5'h03
`define VIH_SLOT_SER0 5'h04
`define VIH_SLOT_RSVD 5'h13
`define VIH_SLOT_SER1 5'h14
// ---------------------------------------------------------------
// Timer control and interrupt enable register bit positions
// ---------------------------------------------------------------
`define VIH_TCR_EXT0_EDGE 0
`define VIH_TCR_EXT0_PEND 1
`define VIH_TCR_EXT1_EDGE 2
`define VIH_TCR_EXT1_PEND 3
`define VIH_IE_GLOBAL_BIT 7
// ---------------------------------------------------------------
// Timing and page constants
// ---------------------------------------------------------------
`define VIH_CALL_CYCLES 3'h4
`define VIH_PAGE_RESET 8'h00
`endif

// ==== hw/vih_ext_pin.v ====
// External active-low interrupt pin synchroniser and pending flag.
`timescale 1ns/100ps
`default_nettype none
module vih_ext_pin (
    input wire clk_in,
    input wire rstn_in,
    input wire pin_n_in,
    input wire edge_select_in,
    input wire sw_set_in,
    input wire sw_clr_in,
    input wire vector_ack_in,
    output reg pending_out
);
    reg [2:0] sync_reg;
    reg active_reg;
    wire agree;
    wire fall;
    // ---------------------------------------------------------------
    // Synchroniser
    // ---------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync_reg <= 3'h7;
            active_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], pin_n_in};
            if (agree) begin
                active_reg <= ~sync_reg[2];
            end
        end
    end
    assign agree = (sync_reg[1] == sync_reg[2]);
    assign fall = agree & ~sync_reg[2] & ~active_reg;
    // ---------------------------------------------------------------
    // Pending flag
    // ---------------------------------------------------------------
    // Edge mode latches falls; level mode tracks the pin. Set wins over clear.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pending_out <= 1'b0;
        end else if (!edge_select_in) begin
            pending_out <= (agree ? ~sync_reg[2] : active_reg) | sw_set_in;
        end else if (fall | sw_set_in) begin
            pending_out <= 1'b1;
        end else if (vector_ack_in | sw_clr_in) begin
            pending_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== bench/vih_top_props.sv ====
// Concurrent checks on the vectored interrupt handler ports.
`timescale 1ns/100ps
`default_nettype none
module vih_top_props (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic instr_done_in,
    input wire logic irq_request_out,
    input wire logic long_call_out,
    input wire logic [15:0] vector_addr_out,
    input wire logic [15:0] return_addr_out,
    input wire logic [15:0] next_pc_in,
    input wire logic return_valid_out,
    input wire logic return_from_irq_in,
    input wire logic page_switch_out,
    input wire logic auto_page_switch_enable_in,
    input wire logic global_irq_enable_in,
    input wire logic [20:0] source_enable_in,
    input wire logic [3:0] timer_control_reg_out,
    input wire logic [3:0] tcr_set_in,
    input wire logic global_clear_in
);
    // ---------------------------------------------------------------
    // Properties, all in the one clock domain.
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_call_after_take: assert property (long_call_out |-> $past(instr_done_in, 4) && $past(irq_request_out, 4)) else $error("call without a take four cycles before");
    a_call_one_pulse: assert property (long_call_out |=> !long_call_out) else $error("call pulse longer than one cycle");
    a_vector_legal: assert property (long_call_out |-> vector_addr_out[2:0] == 3'h3 && vector_addr_out <= 16'h00A3 && vector_addr_out != 16'h009B) else $error("vector outside the slot table");
    a_return_addr_kept: assert property (long_call_out |-> return_addr_out == $past(next_pc_in, 4)) else $error("saved address differs from next address at take");
    a_return_valid_cause: assert property (return_valid_out |-> $past(return_from_irq_in)) else $error("return pulse without a return");
    a_page_with_call: assert property (long_call_out && auto_page_switch_enable_in && $past(auto_page_switch_enable_in, 4) |-> page_switch_out) else $error("page switch missing on entry");
    a_page_only_call: assert property (page_switch_out |-> long_call_out) else $error("page switch outside a call");
    a_global_masks: assert property (!global_irq_enable_in && $past(!global_irq_enable_in) && !$past(global_clear_in) |-> !irq_request_out) else $error("request while globally masked");
    a_none_enabled: assert property (source_enable_in == 21'h000000 |-> !irq_request_out) else $error("request with no source enabled");
    a_edge_flag_clear: assert property (long_call_out && vector_addr_out == 16'h0003 && timer_control_reg_out[0] && !tcr_set_in[1] |=> !timer_control_reg_out[1]) else $error("edge pin flag kept after vectoring");
endmodule
bind vih_top vih_top_props u_vih_top_props (.clk_in(clk_in), .rstn_in(rstn_in),
    .instr_done_in(instr_done_in), .irq_request_out(irq_request_out),
    .long_call_out(long_call_out), .vector_addr_out(vector_addr_out),
    .return_addr_out(return_addr_out), .next_pc_in(next_pc_in),
    .return_valid_out(return_valid_out), .return_from_irq_in(return_from_irq_in),
    .page_switch_out(page_switch_out), .auto_page_switch_enable_in(auto_page_switch_enable_in),
    .global_irq_enable_in(global_irq_enable_in), .source_enable_in(source_enable_in),
    .timer_control_reg_out(timer_control_reg_out), .tcr_set_in(tcr_set_in),
    .global_clear_in(global_clear_in));
`default_nettype wire

// ==== bench/vih_cpu_model.sv ====
// Behavioural instruction sequencer that faces the interrupt handler.
`timescale 1ns/100ps
`default_nettype none
module vih_cpu_model #(
    parameter int ISR_LEN = 3
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic irq_request_in,
    input wire logic long_call_in,
    output logic instr_done_out,
    output logic return_from_irq_out,
    output logic [15:0] next_pc_out
);
    // ---------------------------------------------------------------
    // Two-cycle instructions; pauses from a take until the call lands.
    // ---------------------------------------------------------------
    logic phase_reg;
    logic in_isr_reg;
    logic holdoff_reg;
    logic [2:0] hold_reg;
    logic [3:0] cnt_reg;
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {instr_done_out, return_from_irq_out, phase_reg, in_isr_reg, holdoff_reg} <= 5'h00;
            hold_reg <= 3'h0;
            cnt_reg <= 4'h0;
            next_pc_out <= 16'h0100;
        end else begin
            instr_done_out <= 1'b0;
            return_from_irq_out <= 1'b0;
            phase_reg <= ~phase_reg;
            // The first boundary after a return is never taken; it only ends the hold-off.
            if (instr_done_out) holdoff_reg <= 1'b0;
            if (instr_done_out && irq_request_in && !holdoff_reg) begin
                hold_reg <= 3'h6;
            end else if (long_call_in) begin
                hold_reg <= 3'h0;
                in_isr_reg <= 1'b1;
                cnt_reg <= ISR_LEN[3:0];
            end else if (hold_reg != 3'h0) begin
                hold_reg <= hold_reg - 3'h1;
            end else if (phase_reg) begin
                if (in_isr_reg && cnt_reg == 4'h0) begin
                    return_from_irq_out <= 1'b1;
                    in_isr_reg <= 1'b0;
                    holdoff_reg <= 1'b1;
                end else begin
                    instr_done_out <= 1'b1;
                    next_pc_out <= next_pc_out + 16'h0002;
                    if (in_isr_reg) cnt_reg <= cnt_reg - 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/test_vectored_interrupt_handler.sv ====
// Self-checking bench for the vectored interrupt handler.
`timescale 1ns/100ps
`default_nettype none
module test_vectored_interrupt_handler;
    // ---------------------------------------------------------------
    // Stimulus, expectations and the verdict.
    // ---------------------------------------------------------------
    logic clk_in = 1'b0, rstn_in = 1'b0, pin0_n = 1'b1, pin1_n = 1'b1, edge0 = 1'b0, edge1 = 1'b0;
    logic tmr0 = 1'b0, tmr1 = 1'b0, s0rx = 1'b0, s0tx = 1'b0, s1tx = 1'b0, ga = 1'b0, apse = 1'b0;
    logic s1rx = 1'b0, gclr = 1'b0, multi = 1'b0;
    logic [3:0] tset = 4'h0, tclr = 4'h0;
    logic [7:0] psel;
    logic [1:0] alvl;
    logic [15:0] ev;
    logic [20:0] pend = 21'h0, en = 21'h0, prio = 21'h0;
    logic idone, ret, req, long_call;
    logic [15:0] pc, vec;
    logic [3:0] tcr;
    logic [15:0] exp_q[$];
    int failures = 0, checked = 0;
    always #2 clk_in = ~clk_in;
    vih_top u_vih_top (.clk_in(clk_in), .rstn_in(rstn_in), .ext_irq0_n_in(pin0_n),
        .ext_irq1_n_in(pin1_n), .ext0_edge_select_in(edge0), .ext1_edge_select_in(edge1),
        .tcr_set_in(tset), .tcr_clr_in(tclr), .timer0_overflow_in(tmr0),
        .timer1_overflow_in(tmr1), .serial0_rx_flag_in(s0rx), .serial0_tx_flag_in(s0tx),
        .serial1_rx_flag_in(s1rx), .serial1_tx_flag_in(s1tx), .periph_pending_in(pend),
        .source_enable_in(en), .source_priority_in(prio), .global_irq_enable_in(ga),
        .global_clear_in(gclr), .auto_page_switch_enable_in(apse), .instr_done_in(idone),
        .next_multi_cycle_in(multi), .return_from_irq_in(ret), .next_pc_in(pc),
        .irq_request_out(req), .long_call_out(long_call), .vector_addr_out(vec),
        .return_addr_out(), .return_valid_out(), .page_select_out(psel), .page_switch_out(),
        .timer_control_reg_out(tcr), .active_level_out(alvl));
    vih_cpu_model u_vih_cpu_model (.clk_in(clk_in), .rstn_in(rstn_in), .irq_request_in(req),
        .long_call_in(long_call), .instr_done_out(idone), .return_from_irq_out(ret),
        .next_pc_out(pc));
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
        checked++;
        if (got !== expv) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, expv, got);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Register page that each vector selects on entry when page switching is on.
    function automatic logic [15:0] page_of(input logic [15:0] v);
        int s;
        s = (v - 16'h0003) >> 3;
        if (s == 10 || s == 11 || s == 14 || s == 20) return 16'h0001;
        else if (s == 12 || s == 13 || (s >= 16 && s <= 18)) return 16'h0002;
        else return 16'h0000;
    endfunction
    // Every call takes the oldest expected vector; an unlooked-for call is a mismatch.
    always @(negedge clk_in) begin
        if (long_call === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected call", 16'h0000, vec);
            end else begin
                ev = exp_q.pop_front();
                chk("vector", ev, vec);
                if (apse) chk("page", page_of(ev), {8'h00, psel});
            end
        end
    end
    task automatic wait_call();
        int i;
        for (i = 0; i < 200 && long_call !== 1'b1; i++) @(negedge clk_in);
        if (long_call !== 1'b1) chk("call timeout", 16'h0001, 16'h0000);
        @(negedge clk_in);
    endtask
    // Raises the cause of one order slot and expects its vector.
    task automatic fire(input int n);
        exp_q.push_back(16'h0003 + 16'h0008 * n[15:0]);
        apse = 1'($urandom);
        case (n)
            0: pin0_n = 1'b0;
            1: tmr0 = 1'b1;
            2: tset = 4'h8;
            3: tmr1 = 1'b1;
            4: s0rx = 1'b1;
            20: {s1rx, s1tx} = {apse, ~apse};
            default: pend[n] = 1'b1;
        endcase
        @(negedge clk_in);
        {tmr0, tmr1, tset} = 6'h00;
        wait_call();
        {pin0_n, s0rx, s1rx, s1tx, pend} = {4'b1000, 21'h0};
        repeat (30) @(negedge clk_in);
        chk("pin flags", 16'h0000, {12'h000, tcr[3], 1'b0, tcr[1], 1'b0});
    endtask
    initial begin
        int n;
        void'($urandom(97));
        repeat (8) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (5) @(negedge clk_in);
        {ga, en, edge0, edge1} = {1'b1, 21'h1FFFFF, 2'b11};
        for (n = 0; n <= 20; n++) if (n != 19) fire(n);
        exp_q.push_back(16'h007B);
        exp_q.push_back(16'h0053);
        prio[15] = 1'b1;
        pend = 21'h008400;
        wait_call();
        chk("active level", 16'h0002, {14'h0, alvl});
        pend[15] = 1'b0;
        wait_call();
        pend = 21'h0;
        exp_q.push_back(16'h0023);
        exp_q.push_back(16'h0023);
        s0tx = 1'b1;
        wait_call();
        wait_call();
        s0tx = 1'b0;
        // A clear followed by a multi-cycle instruction masks at once; single-cycle lags one.
        repeat (30) @(negedge clk_in);
        {gclr, multi} = 2'b11;
        @(negedge clk_in);
        {gclr, pend[5]} = 2'b01;
        #1 chk("multi follower", 16'h0000, {15'h0, req});
        exp_q.push_back(16'h002B);
        wait_call();
        pend = 21'h0;
        repeat (30) @(negedge clk_in);
        {gclr, multi} = 2'b10;
        @(negedge clk_in);
        {gclr, pend[5]} = 2'b01;
        #1 chk("single follower", 16'h0001, {15'h0, req});
        exp_q.push_back(16'h002B);
        wait_call();
        pend = 21'h0;
        ga = 1'b0;
        @(negedge clk_in);
        pend = 21'($urandom) | 21'h080000;
        repeat (40) @(negedge clk_in);
        chk("masked request", 16'h0000, {15'h0, req});
        {ga, en} = {1'b1, 21'h000000};
        repeat (40) @(negedge clk_in);
        en = 21'h080000;
        repeat (40) @(negedge clk_in);
        chk("reserved request", 16'h0000, {15'h0, req});
        tset = 4'h8;
        @(negedge clk_in);
        tset = 4'h0;
        chk("soft set", 16'h0001, {15'h0, tcr[3]});
        tclr = 4'h8;
        @(negedge clk_in);
        tclr = 4'h0;
        chk("soft clear", 16'h0000, {15'h0, tcr[3]});
        {pend, edge1, pin1_n} = {21'h0, 2'b00};
        repeat (6) @(negedge clk_in);
        chk("level flag low", 16'h0001, {15'h0, tcr[3]});
        pin1_n = 1'b1;
        repeat (6) @(negedge clk_in);
        chk("level flag high", 16'h0000, {15'h0, tcr[3]});
        chk("calls left", 16'h0000, 16'(exp_q.size()));
        conclude();
    end
    initial begin
        #(20000 * 4);
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
